// File: src/itb_pkg.sv
// Package: shared types and constants for the instruction trace branch output block.
package itb_pkg;

   // ==========================================================
   // Protocol generations
   // ==========================================================
   typedef enum logic [1:0] {ITB_GEN1, ITB_GEN2, ITB_GEN3} itb_gen_t;

   // ==========================================================
   // Exception kinds
   // ==========================================================
   localparam int unsigned ITB_EXC_W = 3;
   typedef enum logic [2:0]
   {
      ITB_EXC_RESET  = 3'h0,
      ITB_EXC_UNDEF  = 3'h1,
      ITB_EXC_SVC    = 3'h2,
      ITB_EXC_PABT   = 3'h3,
      ITB_EXC_DABT   = 3'h4,
      ITB_EXC_SMC    = 3'h5,
      ITB_EXC_IRQ    = 3'h6,
      ITB_EXC_FIQ    = 3'h7
   } itb_exc_t;

   // ==========================================================
   // Vector table layout
   // ==========================================================
   localparam logic [31:0] ITB_VEC_LOW_BASE  = 32'h0000_0000;
   localparam logic [31:0] ITB_VEC_HIGH_BASE = 32'hffff_0000;
   localparam int unsigned ITB_VEC_SHIFT     = 2;
   localparam logic [31:0] ITB_VEC_LAST_OFS  = 32'h0000_001c;
   // Slot index of each exception in the eight-word table (slot 5 is unused).
   localparam logic [2:0]  ITB_SLOT_RESET    = 3'h0;
   localparam logic [2:0]  ITB_SLOT_UNDEF    = 3'h1;
   localparam logic [2:0]  ITB_SLOT_SVC      = 3'h2;
   localparam logic [2:0]  ITB_SLOT_PABT     = 3'h3;
   localparam logic [2:0]  ITB_SLOT_DABT     = 3'h4;
   localparam logic [2:0]  ITB_SLOT_SMC      = 3'h2;
   localparam logic [2:0]  ITB_SLOT_IRQ      = 3'h6;
   localparam logic [2:0]  ITB_SLOT_FIQ      = 3'h7;

   // ==========================================================
   // Retired instruction, as reported by the processor
   // ==========================================================
   typedef enum logic [1:0]
   {
      ITB_FLOW_SEQ,
      ITB_FLOW_DIRECT,
      ITB_FLOW_INDIRECT
   } itb_flow_t;

   typedef struct packed
   {
      logic [31:0] addr;
      logic [31:0] target;
      itb_flow_t   flow;
      logic        state_chg;
      logic        cond_pass;
   } itb_instr_t;

   // ==========================================================
   // Trace element handed to the packet formatter
   // ==========================================================
   typedef struct packed
   {
      logic        has_addr;
      logic [31:0] addr;
      logic        exc_flag;
      itb_exc_t    exc_kind;
      logic        cancelled;
      logic        executed;
      logic        drop_data;
   } itb_elem_t;

endpackage : itb_pkg

// File: src/itb_buf2.sv
// Two-entry valid/ready buffer for trace elements.
`timescale 1ns/1ns
module itb_buf2
   import itb_pkg::*;
(
   // Clock and reset
   input  wire logic              ref_clk_i,
   input  wire logic              nrst_i,
   // Fill side
   input  wire logic              in_valid_i,
   output      logic              in_ready_o,
   input  wire itb_pkg::itb_elem_t in_data_i,
   // Drain side
   output      logic              out_valid_o,
   input  wire logic              out_ready_i,
   output      itb_pkg::itb_elem_t out_data_o
);
   import itb_pkg::*;

   itb_elem_t  mem_r [2];
   logic       wptr_r;
   logic       rptr_r;
   logic [1:0] cnt_r;
   wire        push = in_valid_i && in_ready_o;
   wire        pop  = out_valid_o && out_ready_i;

   assign in_ready_o  = (cnt_r != 2'h2);
   assign out_valid_o = (cnt_r != 2'h0);
   assign out_data_o  = mem_r[rptr_r];

   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         wptr_r   <= 1'b0;
         rptr_r   <= 1'b0;
         cnt_r    <= 2'h0;
         mem_r[0] <= '0;
         mem_r[1] <= '0;
      end
      else
      begin
         if (push)
         begin
            mem_r[wptr_r] <= in_data_i;
            wptr_r        <= ~wptr_r;
         end
         if (pop)
            rptr_r <= ~rptr_r;
         cnt_r <= cnt_r + {1'b0, push} - {1'b0, pop};
      end
   end

endmodule : itb_buf2

// File: src/itb_branch_out.sv
// Branch and exception reporting core of the instruction trace unit.
`timescale 1ns/1ns
// Function
// - Direct branches without a state switch give no destination address, only an executed mark.
// - Indirect flow changes and every exception emit the destination address.
// - Exceptions and state switches are reported by emitting the new address.
// - The trace window enable turns tracing on and off at run time.
// - Vectors sit low when high vectors select is low at the reset branch, high otherwise; later changes do not move them.
// - Third generation flags every exception explicitly with its branch.
// - Reset abandons the instruction; after release a reset-vector branch is traced.
// - Normal or fast interrupt turns the interrupted instruction into a vector branch.
// - A cancelled fetch-aborted instruction branches to the prefetch abort vector.
// - Data abort instruction branches to its vector; its data trace is dropped.
// - Undefined and supervisor call branch to own vectors; secure monitor call shares the supervisor call vector.
// - After an exception branch the next traced instruction is at the vector.
// - Relocatable-vector processors are traced only with the third generation.
module itb_branch_out
   import itb_pkg::*;
#(
   parameter bit RELOC_VECTORS = 1'b0
)
(
   // Clock and reset
   input  wire logic                ref_clk_i,
   input  wire logic                nrst_i,
   // Configuration
   input  wire itb_pkg::itb_gen_t   proto_gen_i,
   input  wire logic                high_vectors_select_i,
   input  wire logic                trace_window_enable_i,
   // Retired instruction stream
   input  wire logic                instr_valid_i,
   output      logic                instr_ready_o,
   input  wire itb_pkg::itb_instr_t instr_i,
   // Exception events
   input  wire logic                exc_valid_i,
   input  wire itb_pkg::itb_exc_t   exc_kind_i,
   input  wire logic [31:0]         exc_addr_i,
   input  wire logic [31:0]         exc_vec_i,
   // Trace element output
   output      logic                elem_valid_o,
   input  wire logic                elem_ready_i,
   output      itb_pkg::itb_elem_t  elem_o,
   // Status
   output      logic                expect_vector_o,
   output      logic                gen_error_o
);
   import itb_pkg::*;

   // ==========================================================
   // Helpers
   // ==========================================================
   function automatic logic [2:0] exc_slot(input itb_exc_t k);
      case (k)
         ITB_EXC_RESET: exc_slot = ITB_SLOT_RESET;
         ITB_EXC_UNDEF: exc_slot = ITB_SLOT_UNDEF;
         ITB_EXC_SVC:   exc_slot = ITB_SLOT_SVC;
         ITB_EXC_PABT:  exc_slot = ITB_SLOT_PABT;
         ITB_EXC_DABT:  exc_slot = ITB_SLOT_DABT;
         ITB_EXC_SMC:   exc_slot = ITB_SLOT_SMC;
         ITB_EXC_IRQ:   exc_slot = ITB_SLOT_IRQ;
         default:       exc_slot = ITB_SLOT_FIQ;
      endcase
   endfunction : exc_slot

   function automatic logic [31:0] vec_addr(input logic hi, input itb_exc_t k);
      logic [31:0] base;
      base     = hi ? ITB_VEC_HIGH_BASE : ITB_VEC_LOW_BASE;
      vec_addr = base | (32'({29'h0, exc_slot(k)}) << ITB_VEC_SHIFT);
   endfunction : vec_addr

   // Cancelling kinds: the faulting or interrupted instruction did not complete.
   function automatic logic exc_cancels(input itb_exc_t k);
      exc_cancels = (k == ITB_EXC_RESET) || (k == ITB_EXC_IRQ) ||
                    (k == ITB_EXC_FIQ) || (k == ITB_EXC_PABT);
   endfunction : exc_cancels

   // ==========================================================
   // Reset tracking
   // ==========================================================
   // The first element after release is the reset-vector branch; the
   // processor's own reset is the block reset, so whatever was in flight is lost.
   typedef enum {ST_RESET_BRANCH, ST_RUN} itb_state_t;
   itb_state_t state_r;
   itb_state_t state_nxt;

   logic       hv_run_r;
   logic       hv_nxt;
   logic       gen_err_r;
   logic       gen_err_nxt;
   logic       expect_r;
   logic       expect_nxt;
   logic [31:0] expect_addr_r;
   logic [31:0] expect_addr_nxt;

   // ==========================================================
   // Element build
   // ==========================================================
   wire        is_gen3   = (proto_gen_i == ITB_GEN3);
   wire        buf_ready;
   wire        in_reset  = (state_r == ST_RESET_BRANCH);
   // The select is still being captured in the reset-branch cycle, so use the pin there.
   wire        hv_cur    = in_reset ? high_vectors_select_i : hv_run_r;
   wire        take_exc  = !in_reset && exc_valid_i;
   wire        take_ins  = !in_reset && !exc_valid_i && instr_valid_i;
   wire        vec_known = RELOC_VECTORS ? 1'b0 : 1'b1;

   // Relocated vectors are honoured only in the third generation.
   wire [31:0] exc_target = (RELOC_VECTORS && is_gen3) ? exc_vec_i
                          : vec_addr(hv_cur, exc_kind_i);
   wire [31:0] rst_target = vec_addr(hv_cur, ITB_EXC_RESET);

   wire        ins_indirect = (instr_i.flow == ITB_FLOW_INDIRECT) ||
                              instr_i.state_chg;
   wire        ins_direct   = (instr_i.flow == ITB_FLOW_DIRECT);

   itb_elem_t elem_nxt;
   logic      elem_vld_nxt;

   always_comb
   begin
      elem_nxt     = '0;
      elem_vld_nxt = 1'b0;
      if (in_reset)
      begin
         elem_vld_nxt      = 1'b1;
         elem_nxt.has_addr = 1'b1;
         elem_nxt.addr     = rst_target;
         elem_nxt.exc_flag = is_gen3;
         elem_nxt.exc_kind = ITB_EXC_RESET;
         elem_nxt.cancelled = 1'b1;
      end
      else if (take_exc)
      begin
         // Exceptions always carry their vector address.
         elem_vld_nxt       = 1'b1;
         elem_nxt.has_addr  = 1'b1;
         elem_nxt.addr      = exc_target;
         elem_nxt.exc_flag  = is_gen3;
         elem_nxt.exc_kind  = exc_kind_i;
         elem_nxt.cancelled = exc_cancels(exc_kind_i);
         elem_nxt.executed  = !exc_cancels(exc_kind_i);
         elem_nxt.drop_data = (exc_kind_i == ITB_EXC_DABT);
      end
      else if (take_ins)
      begin
         elem_vld_nxt       = 1'b1;
         elem_nxt.has_addr  = ins_indirect && instr_i.cond_pass;
         elem_nxt.addr      = ins_indirect ? instr_i.target : instr_i.addr;
         elem_nxt.executed  = instr_i.cond_pass || ins_direct;
      end
   end

   // Tracing off inside the window drops elements but keeps the pipeline moving.
   wire emit = elem_vld_nxt && (trace_window_enable_i || in_reset);

   assign instr_ready_o = !in_reset && !exc_valid_i && buf_ready;

   // ==========================================================
   // State update
   // ==========================================================
   // An event is consumed only when the buffer could take it, as the ready output promises.
   wire step = buf_ready;

   always_comb
   begin
      state_nxt       = state_r;
      hv_nxt          = hv_run_r;
      expect_nxt      = expect_r;
      expect_addr_nxt = expect_addr_r;
      gen_err_nxt     = gen_err_r;
      case (state_r)
         ST_RESET_BRANCH:
            if (buf_ready)
            begin
               state_nxt       = ST_RUN;
               expect_nxt      = 1'b1;
               expect_addr_nxt = rst_target;
            end
         ST_RUN:
         begin
            if (take_exc && step)
            begin
               expect_nxt      = 1'b1;
               expect_addr_nxt = exc_target;
            end
            else if (take_ins && step)
            begin
               // The first instruction after an exception must sit on the vector.
               if (expect_r && instr_i.addr != expect_addr_r)
                  gen_err_nxt = 1'b1;
               expect_nxt = 1'b0;
            end
            // Older generations rely on a constant vector select for the whole run.
            if (!is_gen3 && (high_vectors_select_i != hv_run_r))
               gen_err_nxt = 1'b1;
            if (!is_gen3 && !vec_known)
               gen_err_nxt = 1'b1;
         end
         default:
            state_nxt = ST_RESET_BRANCH;
      endcase
   end

   // The vector select is captured by a clocked load in the reset-branch state.
   always_ff @(posedge ref_clk_i or negedge nrst_i)
   begin
      if (!nrst_i)
      begin
         state_r       <= ST_RESET_BRANCH;
         hv_run_r      <= 1'b0;
         expect_r      <= 1'b0;
         expect_addr_r <= 32'h0000_0000;
         gen_err_r     <= 1'b0;
      end
      else
      begin
         state_r       <= state_nxt;
         hv_run_r      <= in_reset ? high_vectors_select_i : hv_nxt;
         expect_r      <= expect_nxt;
         expect_addr_r <= expect_addr_nxt;
         gen_err_r     <= gen_err_nxt;
      end
   end

   // ==========================================================
   // Output buffer
   // ==========================================================
   // Two entries let a receiver stall for a cycle without losing a branch.
   itb_buf2 u_buf
   (
      .ref_clk_i   (ref_clk_i),
      .nrst_i      (nrst_i),
      .in_valid_i  (emit),
      .in_ready_o  (buf_ready),
      .in_data_i   (elem_nxt),
      .out_valid_o (elem_valid_o),
      .out_ready_i (elem_ready_i),
      .out_data_o  (elem_o)
   );

   assign expect_vector_o = expect_r;
   assign gen_error_o     = gen_err_r;

   // A table whose last slot misses the last offset cannot be served by the slot decode.
   if (ITB_VEC_LAST_OFS != (32'h0000_0007 << ITB_VEC_SHIFT))
   begin : g_bad_table
      $error("Vector table size does not match the slot layout.");
   end

endmodule : itb_branch_out

// File: tb/itb_branch_out_props.sv
// Checker for the branch output core, bound to its ports.
`timescale 1ns/1ns
module itb_branch_out_props
   import itb_pkg::*;
#(
   parameter bit RELOC_VECTORS = 1'b0
)
(
   // Clock, reset and configuration
   input wire logic                ref_clk_i,
   input wire logic                nrst_i,
   input wire itb_pkg::itb_gen_t   proto_gen_i,
   input wire logic                high_vectors_select_i,
   input wire logic                trace_window_enable_i,
   // Instruction and exception side
   input wire logic                instr_valid_i,
   input wire logic                instr_ready_o,
   input wire itb_pkg::itb_instr_t instr_i,
   input wire logic                exc_valid_i,
   input wire itb_pkg::itb_exc_t   exc_kind_i,
   input wire logic [31:0]         exc_addr_i,
   input wire logic [31:0]         exc_vec_i,
   // Element side and status
   input wire logic                elem_valid_o,
   input wire logic                elem_ready_i,
   input wire itb_pkg::itb_elem_t  elem_o,
   input wire logic                expect_vector_o,
   input wire logic                gen_error_o
);
   // ========
   // Helpers
   wire logic        gen3 = (proto_gen_i == ITB_GEN3);
   wire logic [31:0] base = high_vectors_select_i ? ITB_VEC_HIGH_BASE : ITB_VEC_LOW_BASE;
   wire logic [2:0]  slot = (exc_kind_i == ITB_EXC_SMC) ? ITB_SLOT_SMC : 3'(exc_kind_i);
   wire logic [31:0] vec  = base | {27'h0, slot, 2'h0};
   default clocking cb @(posedge ref_clk_i); endclocking
   default disable iff (!nrst_i);
   // An empty buffer makes the element show one cycle later.
   sequence s_exc_take;
      exc_valid_i && !elem_valid_o && trace_window_enable_i && !(RELOC_VECTORS && gen3)
         && !$rose(nrst_i);
   endsequence
   sequence s_take(itb_flow_t f);
      instr_valid_i && instr_ready_o && instr_i.flow == f && instr_i.cond_pass
         && !instr_i.state_chg && !elem_valid_o && trace_window_enable_i;
   endsequence
   // ========
   // Properties
   a_reset_branch: assert property ($rose(nrst_i) |-> !instr_ready_o ##1 elem_valid_o
      && elem_o.has_addr && elem_o.cancelled && elem_o.addr == base && elem_o.exc_flag == gen3)
      else $error("reset branch wrong");
   a_exc_first: assert property (exc_valid_i |-> !instr_ready_o)
      else $error("instruction taken beside exception");
   a_elem_stands: assert property (elem_valid_o && !elem_ready_i |=>
      elem_valid_o && $stable(elem_o)) else $error("element changed while stalled");
   a_direct_bare: assert property (s_take(ITB_FLOW_DIRECT) |=> elem_valid_o
      && !elem_o.has_addr && elem_o.executed) else $error("direct branch wrong");
   a_indirect_addr: assert property (s_take(ITB_FLOW_INDIRECT) |=> elem_valid_o
      && elem_o.has_addr && elem_o.addr == $past(instr_i.target)) else $error("indirect wrong");
   a_exc_vector: assert property (s_exc_take |=> elem_o.has_addr
      && elem_o.addr == $past(vec)) else $error("exception vector wrong");
   a_exc_flagged: assert property (s_exc_take |=> elem_o.exc_flag == gen3)
      else $error("exception flag wrong");
   a_abort_drop: assert property (s_exc_take ##0 exc_kind_i == ITB_EXC_DABT
      |=> elem_o.drop_data) else $error("abort data kept");
   a_exc_expect: assert property (s_exc_take |=> expect_vector_o)
      else $error("vector expectation missing");
   a_window_off: assert property (!trace_window_enable_i && !elem_valid_o
      && !$rose(nrst_i) |=> !elem_valid_o) else $error("element with window off");
   a_error_sticky: assert property (gen_error_o |=> gen_error_o)
      else $error("error flag dropped");
endmodule : itb_branch_out_props

bind itb_branch_out itb_branch_out_props #(.RELOC_VECTORS(RELOC_VECTORS)) props_i (
   .ref_clk_i(ref_clk_i), .nrst_i(nrst_i), .proto_gen_i(proto_gen_i),
   .high_vectors_select_i(high_vectors_select_i), .trace_window_enable_i(trace_window_enable_i),
   .instr_valid_i(instr_valid_i), .instr_ready_o(instr_ready_o), .instr_i(instr_i),
   .exc_valid_i(exc_valid_i), .exc_kind_i(exc_kind_i), .exc_addr_i(exc_addr_i),
   .exc_vec_i(exc_vec_i), .elem_valid_o(elem_valid_o), .elem_ready_i(elem_ready_i),
   .elem_o(elem_o), .expect_vector_o(expect_vector_o), .gen_error_o(gen_error_o));

// File: tb/itb_decomp_model.sv
// Trace decompressor model that consumes trace elements.
`timescale 1ns/1ns
module itb_decomp_model
   import itb_pkg::*;
(
   // Clock and reset
   input  wire logic               ref_clk_i,
   input  wire logic               nrst_i,
   // Element stream and bench control
   input  wire logic               elem_valid_i,
   output      logic               elem_ready_o,
   input  wire itb_pkg::itb_elem_t elem_i,
   input  wire logic               stall_i
);
   itb_elem_t   got[$];
   int unsigned exc_seen = 0;
   // Ready moves only after an edge, so a stall never splits a handshake.
   always_ff @(posedge ref_clk_i or negedge nrst_i)
      if (!nrst_i)
         elem_ready_o <= 1'b0;
      else
         elem_ready_o <= !stall_i;
   // Reset empties the queue so that no element survives into the next run.
   always @(posedge ref_clk_i or negedge nrst_i)
      if (!nrst_i)
         got.delete();
      else if (elem_valid_i && elem_ready_o)
      begin
         got.push_back(elem_i);
         if (elem_i.exc_flag || elem_i.cancelled)
            exc_seen++;
      end
endmodule : itb_decomp_model

// File: tb/testbench.sv
// Self-checking bench for the branch output core.
`timescale 1ns/1ns
module testbench;
   import itb_pkg::*;
   logic       ref_clk = 1'b0;
   logic       nrst    = 1'b0;
   itb_gen_t   gen     = ITB_GEN3;
   logic       hv      = 1'b0;
   logic       twe     = 1'b1;
   logic       ivalid  = 1'b0;
   itb_instr_t instr   = '0;
   logic       evalid  = 1'b0;
   itb_exc_t   ekind   = ITB_EXC_RESET;
   logic       stall   = 1'b0;
   logic       iready, evld, erdy, expv, gerr;
   itb_elem_t  elem, last;
   int         bad_count = 0;
   int         cmp_count = 0;
   logic [2:0] slots [8] = '{ITB_SLOT_RESET, ITB_SLOT_UNDEF, ITB_SLOT_SVC, ITB_SLOT_PABT,
                             ITB_SLOT_DABT, ITB_SLOT_SMC, ITB_SLOT_IRQ, ITB_SLOT_FIQ};
   initial forever #50 ref_clk = !ref_clk;
   itb_branch_out itb_branch_out_i (.ref_clk_i(ref_clk), .nrst_i(nrst), .proto_gen_i(gen),
      .high_vectors_select_i(hv), .trace_window_enable_i(twe), .instr_valid_i(ivalid),
      .instr_ready_o(iready), .instr_i(instr), .exc_valid_i(evalid), .exc_kind_i(ekind),
      .exc_addr_i(32'h0000_0100), .exc_vec_i(32'h0000_0000), .elem_valid_o(evld),
      .elem_ready_i(erdy), .elem_o(elem), .expect_vector_o(expv), .gen_error_o(gerr));
   itb_decomp_model itb_decomp_model_i (.ref_clk_i(ref_clk), .nrst_i(nrst),
      .elem_valid_i(evld), .elem_ready_o(erdy), .elem_i(elem), .stall_i(stall));
   // ========
   // Common tasks
   task automatic end_sim;
      $display("comparisons %0d mismatches %0d", cmp_count, bad_count);
      if (bad_count == 0 && cmp_count > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask : end_sim
   task automatic chk(string what, logic [31:0] exp, logic [31:0] got);
      cmp_count++;
      if (got !== exp)
      begin
         bad_count++;
         $display("CHECK FAILED %s expected %h seen %h", what, exp, got);
      end
   endtask : chk
   task automatic chk_elem(logic has, logic [31:0] addr, logic flag);
      int n;
      n = 0;
      while (itb_decomp_model_i.got.size() == 0 && n < 50)
      begin
         @(negedge ref_clk);
         n++;
      end
      chk("element present", 1, 32'(n < 50));
      last = itb_decomp_model_i.got.pop_front();
      chk("has_addr", 32'(has), 32'(last.has_addr));
      if (has)
         chk("addr", addr, last.addr);
      chk("exc_flag", 32'(flag), 32'(last.exc_flag));
   endtask : chk_elem
   task automatic do_reset(itb_gen_t g, logic h);
      @(negedge ref_clk);
      nrst = 1'b0;
      gen = g;
      hv = h;
      repeat (8) @(negedge ref_clk);
      nrst = 1'b1;
      @(negedge ref_clk);
      chk_elem(1'b1, h ? ITB_VEC_HIGH_BASE : ITB_VEC_LOW_BASE, g == ITB_GEN3);
      chk("cancelled", 1, 32'(last.cancelled));
   endtask : do_reset
   task automatic send(logic [31:0] a, logic [31:0] t, itb_flow_t f, logic sc, logic cp);
      int n;
      instr = '{addr: a, target: t, flow: f, state_chg: sc, cond_pass: cp};
      ivalid = 1'b1;
      n = 0;
      while (iready !== 1'b1 && n < 50)
      begin
         @(negedge ref_clk);
         n++;
      end
      chk("instr taken", 1, 32'(n < 50));
      @(negedge ref_clk);
      ivalid = 1'b0;
   endtask : send
   task automatic send_exc(itb_exc_t k);
      ekind = k;
      evalid = 1'b1;
      @(negedge ref_clk);
      evalid = 1'b0;
   endtask : send_exc
   // ========
   // Scenarios
   task automatic t_flows;
      do_reset(ITB_GEN3, 1'b0);
      send(32'h0000_0000, 32'h0000_0000, ITB_FLOW_SEQ, 1'b0, 1'b1);
      chk_elem(1'b0, 32'h0000_0000, 1'b0);
      send(32'h0000_0004, 32'h0000_0400, ITB_FLOW_DIRECT, 1'b0, 1'b1);
      chk_elem(1'b0, 32'h0000_0000, 1'b0);
      chk("executed", 1, 32'(last.executed));
      send(32'h0000_0400, 32'h0000_2000, ITB_FLOW_INDIRECT, 1'b0, 1'b1);
      chk_elem(1'b1, 32'h0000_2000, 1'b0);
      send(32'h0000_2000, 32'h0000_3000, ITB_FLOW_INDIRECT, 1'b0, 1'b0);
      chk_elem(1'b0, 32'h0000_0000, 1'b0);
      send(32'h0000_2004, 32'h0000_4001, ITB_FLOW_DIRECT, 1'b1, 1'b1);
      chk_elem(1'b1, 32'h0000_4001, 1'b0);
   endtask : t_flows
   task automatic t_exceptions(itb_gen_t g, logic h);
      logic [31:0] v;
      do_reset(g, h);
      v = h ? ITB_VEC_HIGH_BASE : ITB_VEC_LOW_BASE;
      send(v, v, ITB_FLOW_SEQ, 1'b0, 1'b1);
      chk_elem(1'b0, 32'h0000_0000, 1'b0);
      for (int k = 0; k < 8; k++)
      begin
         v = (h ? ITB_VEC_HIGH_BASE : ITB_VEC_LOW_BASE) | {27'h0, slots[k], 2'h0};
         send_exc(itb_exc_t'(k));
         chk_elem(1'b1, v, g == ITB_GEN3);
         chk("drop_data", 32'(k == 4), 32'(last.drop_data));
         chk("cancelled", 32'(k == 0 || k == 3 || k > 5), 32'(last.cancelled));
         chk("executed", 32'(k inside {1, 2, 4, 5}), 32'(last.executed));
         chk("expect vector", 1, 32'(expv));
         send(v, v, ITB_FLOW_SEQ, 1'b0, 1'b1);
         chk_elem(1'b0, 32'h0000_0000, 1'b0);
         chk("gen error", 0, 32'(gerr));
      end
   endtask : t_exceptions
   task automatic t_errors;
      do_reset(ITB_GEN3, 1'b0);
      send_exc(ITB_EXC_IRQ);
      chk_elem(1'b1, {27'h0, ITB_SLOT_IRQ, 2'h0}, 1'b1);
      send(32'h0000_8000, 32'h0000_8000, ITB_FLOW_SEQ, 1'b0, 1'b1);
      chk_elem(1'b0, 32'h0000_0000, 1'b0);
      chk("gen error", 1, 32'(gerr));
      do_reset(ITB_GEN1, 1'b0);
      hv = 1'b1;
      repeat (2) @(negedge ref_clk);
      chk("gen error", 1, 32'(gerr));
   endtask : t_errors
   task automatic t_window_buffer;
      int taken;
      do_reset(ITB_GEN3, 1'b0);
      twe = 1'b0;
      send(32'h0000_0000, 32'h0000_5000, ITB_FLOW_INDIRECT, 1'b0, 1'b1);
      twe = 1'b1;
      @(negedge ref_clk);
      send(32'h0000_5000, 32'h0000_6000, ITB_FLOW_INDIRECT, 1'b0, 1'b1);
      chk_elem(1'b1, 32'h0000_6000, 1'b0);
      chk("queue left", 0, itb_decomp_model_i.got.size());
      stall = 1'b1;
      @(negedge ref_clk);
      instr.target = 32'h0000_7000;
      ivalid = 1'b1;
      taken = 0;
      repeat (6)
      begin
         if (iready === 1'b1)
            taken++;
         @(negedge ref_clk);
         instr.target = 32'h0000_7000 + 32'(taken) * 32'h0000_0010;
      end
      ivalid = 1'b0;
      chk("words held", 2, taken);
      stall = 1'b0;
      chk_elem(1'b1, 32'h0000_7000, 1'b0);
      chk_elem(1'b1, 32'h0000_7010, 1'b0);
      repeat (4) @(negedge ref_clk);
      chk("drained", 0, 32'(evld));
   endtask : t_window_buffer
   initial
   begin
      for (int g = 0; g < 3; g++)
         for (int h = 0; h < 2; h++)
            do_reset(itb_gen_t'(g), h[0]);
      t_flows();
      t_exceptions(ITB_GEN1, 1'b1);
      t_exceptions(ITB_GEN3, 1'b0);
      t_errors();
      t_window_buffer();
      end_sim();
   end
   // The whole run needs under two thousand cycles; ten times that means a hang.
   initial
   begin
      #(20000 * 100);
      bad_count++;
      end_sim();
   end
endmodule : testbench
